// File: tcto_assertions.sv
// checker on the timer control block ports
`timescale 1ns/100ps
`default_nettype none
module tcto_chk
    import tcto_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic              clock,
    input wire logic              rst_b,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire logic              external_irq_pin_1,
    input wire logic              counter_pin_0_out,
    input wire logic              counter_pin_0_oe_n,
    input wire logic              counter_pin_1_out,
    input wire logic              irq
);
    // ************************************************************
    // shadows of software fields not visible at the ports
    // ************************************************************
    logic       wr_hit;
    logic       run0_q;
    logic       pin_qualified_run_1_q;
    logic       mask_q;
    // a write lands only at the access edge with pready
    assign wr_hit = psel && penable && pready && pwrite && pstrb[0];
    // shadow the run, gate and mask bits as they are written
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            run0_q  <= 1'b0;
            pin_qualified_run_1_q <= 1'b0;
            mask_q  <= 1'b0;
        end
        else if (wr_hit && paddr == ADDR_W'({TCTO_IDX_RUN_FLAG, 2'b00}))
            run0_q  <= pwdata[TCTO_RUN0_BIT];
        else if (wr_hit && paddr == ADDR_W'({TCTO_IDX_MODE_SEL, 2'b00}))
            pin_qualified_run_1_q <= pwdata[4+TCTO_GATE_OFS];
        else if (wr_hit && paddr == ADDR_W'({TCTO_IDX_IRQ_MASK, 2'b00}))
            mask_q  <= |pwdata[3:0];
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_setup;
        psel && !penable;
    endsequence
    ready_timing_a: assert property (s_setup |=> pready) else $error("pready late");
    unmapped_err_a: assert property (psel && !penable && paddr[ADDR_W-1 -: 2] != 2'b00 |=> pslverr)
        else $error("no error on unmapped address");
    slverr_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    idle_zero_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata idle");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    toggle_enable_a: assert property ($changed(counter_pin_0_out) |-> !$past(counter_pin_0_oe_n))
        else $error("pin 0 toggled while disabled");
    run_stop_a: assert property (!run0_q [*4] |=> $stable(counter_pin_0_out))
        else $error("timer 0 moved while stopped");
    gate_freeze_a: assert property ((pin_qualified_run_1_q && !external_irq_pin_1) [*4] |=> $stable(counter_pin_1_out))
        else $error("pin 1 moved while gated");
    irq_mask_a: assert property (!mask_q [*3] |=> !irq) else $error("irq while masked");
endmodule
bind tcto_timer_ctrl tcto_chk #(.ADDR_W(ADDR_W)) i_chk
(
    .clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
    .pslverr, .external_irq_pin_1, .counter_pin_0_out, .counter_pin_0_oe_n,
    .counter_pin_1_out, .irq
);
`default_nettype wire

// File: tcto_pin_load.sv
// load on one counter pin: measures toggle edges and half periods
`timescale 1ns/100ps
`default_nettype none
module tcto_pin_load
(
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic drv,
    input  wire logic oe_n,
    output logic      level,
    output int        edges,
    output int        half
);
    int   run_len;
    logic prev;
    assign level = oe_n ? 1'b1 : drv; // released pin rests at its pull-up
    // count edges and cycles between them
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            edges   <= 0;
            half    <= 0;
            run_len <= 1;
            prev    <= 1'b1;
        end
        else
        begin
            prev    <= level;
            run_len <= (level != prev) ? 1 : run_len + 1;
            if (level != prev)
            begin
                edges <= edges + 1;
                half  <= run_len;
            end
        end
    end
endmodule
`default_nettype wire

// File: tcto_pkg.sv
// constants shared by the timer control and toggle output block
package tcto_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] TCTO_IDX_RUN_FLAG  = 8'h88;
    localparam logic [7:0] TCTO_IDX_MODE_SEL  = 8'h89;
    localparam logic [7:0] TCTO_IDX_OUT_EN    = 8'h91;
    localparam logic [7:0] TCTO_IDX_LOW_0     = 8'h8A;
    localparam logic [7:0] TCTO_IDX_LOW_1     = 8'h8B;
    localparam logic [7:0] TCTO_IDX_HIGH_0    = 8'h8C;
    localparam logic [7:0] TCTO_IDX_HIGH_1    = 8'h8D;
    localparam logic [7:0] TCTO_IDX_PRESCALE  = 8'hC0;
    localparam logic [7:0] TCTO_IDX_IRQ_STAT  = 8'hC1;
    localparam logic [7:0] TCTO_IDX_IRQ_MASK  = 8'hC2;

    // timer_run_and_flag_control bit positions
    localparam int TCTO_OVF1_BIT   = 7;
    localparam int TCTO_RUN1_BIT   = 6;
    localparam int TCTO_OVF0_BIT   = 5;
    localparam int TCTO_RUN0_BIT   = 4;
    localparam int TCTO_EXT1_BIT   = 3;
    localparam int TCTO_TYPE1_BIT  = 2;
    localparam int TCTO_EXT0_BIT   = 1;
    localparam int TCTO_TYPE0_BIT  = 0;

    // timer_counter_mode_select: per timer nibble, timer 1 in the upper one
    localparam int TCTO_GATE_OFS   = 3;
    localparam int TCTO_CSEL_OFS   = 2;
    localparam int TCTO_MODE_OFS   = 0;

    // timer_output_enable_control bit positions
    localparam int TCTO_TOG1_BIT   = 7;
    localparam int TCTO_TOG0_BIT   = 6;
    localparam int TCTO_SERIAL_SYNC_PERIPHERAL_MODE_BIT   = 5;
    localparam logic [7:0] TCTO_OUT_EN_MASK = 8'hE0;

    // interrupt status / mask layout
    localparam int TCTO_EV_OVF0    = 0;
    localparam int TCTO_EV_OVF1    = 1;
    localparam int TCTO_EV_EXT0    = 2;
    localparam int TCTO_EV_EXT1    = 3;
    localparam int TCTO_EV_N       = 4;

    // values after reset
    localparam logic [7:0]  TCTO_RST_BYTE = 8'h00;
    localparam logic [31:0] TCTO_RST_WORD = 32'h0000_0000;

    // mode field encodings
    typedef enum logic [1:0]
    {
        TCTO_MODE_13BIT  = 2'b00,
        TCTO_MODE_16BIT  = 2'b01,
        TCTO_MODE_RELOAD = 2'b10,
        TCTO_MODE_STOP   = 2'b11
    } tcto_mode_t;

endpackage

// File: tcto_timer_ctrl.sv
// timer control, external interrupt flags and pin toggle outputs behind apb
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module tcto_timer_ctrl
    import tcto_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int PRE_W  = 8
)
(
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              external_irq_pin_0,
    input  wire logic              external_irq_pin_1,
    input  wire logic              vector_ack_timer_0,
    input  wire logic              vector_ack_timer_1,
    input  wire logic              vector_ack_ext_0,
    input  wire logic              vector_ack_ext_1,
    input  wire logic              counter_pin_0_in,
    input  wire logic              counter_pin_1_in,
    output logic                   counter_pin_0_out,
    output logic                   counter_pin_0_oe_n,
    output logic                   counter_pin_1_out,
    output logic                   counter_pin_1_oe_n,
    output logic                   baud_tick_timer_1,
    output logic                   serial_sync_peripheral_mode,
    output logic                   irq
);

    // whole state of the block
    typedef struct packed
    {
        logic [7:0]          run_flag;
        logic [7:0]          mode_sel;
        logic [7:0]          out_en;
        logic [7:0]          low_0;
        logic [7:0]          high_0;
        logic [7:0]          low_1;
        logic [7:0]          high_1;
        logic [PRE_W-1:0]    prescale;
        logic [PRE_W-1:0]    pre_cnt;
        logic [TCTO_EV_N-1:0] stat;
        logic [TCTO_EV_N-1:0] mask;
        logic [1:0]          cnt_pin_q;
        logic [1:0]          ext_pin_q;
        logic [1:0]          toggle;
        logic                baud_tick;
        logic                irq;
        logic                pready;
        logic [31:0]         prdata;
        logic                pslverr;
    } tcto_state_t;

    tcto_state_t state_reg;
    tcto_state_t state_next;

    // one count step: returns {overflow, high, low}
    function automatic logic [16:0] tcto_step(
        input logic [1:0] mode,
        input logic [7:0] high,
        input logic [7:0] low
    );
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0]  c8;
        tcto_step = {1'b0, high, low};
        c13 = {1'b0, high, low[4:0]} + 14'h0001;
        c16 = {1'b0, high, low} + 17'h0_0001;
        c8  = {1'b0, low} + 9'h001;
        case (mode)
            TCTO_MODE_13BIT:
            begin
                tcto_step = {c13[13], c13[12:5], low[7:5], c13[4:0]};
            end
            TCTO_MODE_16BIT:
            begin
                tcto_step = c16;
            end
            TCTO_MODE_RELOAD:
            begin
                tcto_step = {c8[8], high, (c8[8] ? high : c8[7:0])};
            end
            default:
            begin
                tcto_step = {1'b0, high, low};
            end
        endcase
    endfunction

    // register read mux; returns {hit, data}
    function automatic logic [32:0] tcto_read(
        input logic [7:0]  idx,
        input tcto_state_t s
    );
        tcto_read = {1'b1, TCTO_RST_WORD};
        case (idx)
            TCTO_IDX_RUN_FLAG: tcto_read[7:0] = s.run_flag;
            TCTO_IDX_MODE_SEL: tcto_read[7:0] = s.mode_sel;
            TCTO_IDX_OUT_EN:   tcto_read[7:0] = s.out_en;
            TCTO_IDX_LOW_0:    tcto_read[7:0] = s.low_0;
            TCTO_IDX_HIGH_0:   tcto_read[7:0] = s.high_0;
            TCTO_IDX_LOW_1:    tcto_read[7:0] = s.low_1;
            TCTO_IDX_HIGH_1:   tcto_read[7:0] = s.high_1;
            TCTO_IDX_PRESCALE: tcto_read[PRE_W-1:0] = s.prescale;
            TCTO_IDX_IRQ_STAT: tcto_read[TCTO_EV_N-1:0] = s.stat;
            TCTO_IDX_IRQ_MASK: tcto_read[TCTO_EV_N-1:0] = s.mask;
            default:           tcto_read = {1'b0, TCTO_RST_WORD};
        endcase
    endfunction

    // next-state logic
    always_comb
    begin
        logic [7:0]  idx;
        logic        aligned;
        logic        setup;
        logic        wr;
        logic        rd;
        logic        tick;
        logic [1:0]  run;
        logic [1:0]  gate;
        logic [1:0]  csel;
        logic [1:0]  fall;
        logic [1:0]  ext_pin;
        logic [1:0]  ext_set;
        logic [1:0]  en;
        logic [1:0]  ovf;
        logic [16:0] st0;
        logic [16:0] st1;
        logic [32:0] rdv;
        logic [TCTO_EV_N-1:0] ev;

        state_next = state_reg;
        idx        = paddr[9:2];
        aligned    = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
        setup      = psel && !penable;
        wr         = psel && penable && state_reg.pready && pwrite && aligned && pstrb[0];
        rd         = psel && penable && state_reg.pready && !pwrite && aligned;
        ext_pin    = {external_irq_pin_1, external_irq_pin_0};

        // software writes land at the access edge; hardware terms follow
        if (wr)
        begin
            case (idx)
                TCTO_IDX_RUN_FLAG: state_next.run_flag = pwdata[7:0];
                TCTO_IDX_MODE_SEL: state_next.mode_sel = pwdata[7:0];
                TCTO_IDX_OUT_EN:   state_next.out_en   = pwdata[7:0] & TCTO_OUT_EN_MASK;
                TCTO_IDX_LOW_0:    state_next.low_0    = pwdata[7:0];
                TCTO_IDX_HIGH_0:   state_next.high_0   = pwdata[7:0];
                TCTO_IDX_LOW_1:    state_next.low_1    = pwdata[7:0];
                TCTO_IDX_HIGH_1:   state_next.high_1   = pwdata[7:0];
                TCTO_IDX_PRESCALE: state_next.prescale = pwdata[PRE_W-1:0];
                TCTO_IDX_IRQ_MASK: state_next.mask     = pwdata[TCTO_EV_N-1:0];
                default:           state_next.pslverr  = state_reg.pslverr;
            endcase
        end

        // shared prescaler: one count tick every prescale+1 clocks
        tick = (state_reg.pre_cnt == state_reg.prescale);
        state_next.pre_cnt = tick ? '0 : state_reg.pre_cnt + 1'b1;

        // count enable per timer
        // run bit gate
        run  = {state_reg.run_flag[TCTO_RUN1_BIT], state_reg.run_flag[TCTO_RUN0_BIT]};
        gate = {state_reg.mode_sel[4 + TCTO_GATE_OFS], state_reg.mode_sel[TCTO_GATE_OFS]};
        csel = {state_reg.mode_sel[4 + TCTO_CSEL_OFS], state_reg.mode_sel[TCTO_CSEL_OFS]};
        fall = state_reg.cnt_pin_q & ~{counter_pin_1_in, counter_pin_0_in};
        en   = run & (~gate | ext_pin) & (csel & fall | ~csel & {tick, tick});

        st0 = tcto_step(state_reg.mode_sel[TCTO_MODE_OFS +: 2], state_reg.high_0,
                        state_reg.low_0);
        st1 = tcto_step(state_reg.mode_sel[4 + TCTO_MODE_OFS +: 2], state_reg.high_1,
                        state_reg.low_1);
        ovf = {en[1] & st1[16], en[0] & st0[16]};
        if (en[0])
        begin
            {state_next.high_0, state_next.low_0} = st0[15:0];
        end
        if (en[1])
        begin
            {state_next.high_1, state_next.low_1} = st1[15:0];
        end

        // overflow flags: vector clears, overflow sets and wins
        // overflow flags
        if (vector_ack_timer_0)
        begin
            state_next.run_flag[TCTO_OVF0_BIT] = 1'b0;
        end
        if (vector_ack_timer_1)
        begin
            state_next.run_flag[TCTO_OVF1_BIT] = 1'b0;
        end
        if (ovf[0])
        begin
            state_next.run_flag[TCTO_OVF0_BIT] = 1'b1;
        end
        if (ovf[1])
        begin
            state_next.run_flag[TCTO_OVF1_BIT] = 1'b1;
        end

        // external interrupt flags
        // edge or level select
        ext_set[0] = state_reg.run_flag[TCTO_TYPE0_BIT] ?
                     (state_reg.ext_pin_q[0] & ~ext_pin[0]) : ~ext_pin[0];
        ext_set[1] = state_reg.run_flag[TCTO_TYPE1_BIT] ?
                     (state_reg.ext_pin_q[1] & ~ext_pin[1]) : ~ext_pin[1];
        if (vector_ack_ext_0)
        begin
            state_next.run_flag[TCTO_EXT0_BIT] = 1'b0;
        end
        if (vector_ack_ext_1)
        begin
            state_next.run_flag[TCTO_EXT1_BIT] = 1'b0;
        end
        if (ext_set[0])
        begin
            state_next.run_flag[TCTO_EXT0_BIT] = 1'b1;
        end
        if (ext_set[1])
        begin
            state_next.run_flag[TCTO_EXT1_BIT] = 1'b1;
        end
        state_next.cnt_pin_q = {counter_pin_1_in, counter_pin_0_in};
        state_next.ext_pin_q = ext_pin;

        // toggle flip-flops, each gated by its own enable only
        // invert pin on overflow
        if (ovf[0] && state_reg.out_en[TCTO_TOG0_BIT])
        begin
            state_next.toggle[0] = ~state_reg.toggle[0];
        end
        if (ovf[1] && state_reg.out_en[TCTO_TOG1_BIT])
        begin
            state_next.toggle[1] = ~state_reg.toggle[1];
        end
        state_next.baud_tick = ovf[1];

        // sticky status: a read clears, a new event in the same cycle wins
        ev = {ext_set[1] & ~state_reg.run_flag[TCTO_EXT1_BIT],
              ext_set[0] & ~state_reg.run_flag[TCTO_EXT0_BIT], ovf};
        if (rd && idx == TCTO_IDX_IRQ_STAT)
        begin
            state_next.stat = '0;
        end
        state_next.stat = state_next.stat | ev;
        state_next.irq  = |(state_next.stat & state_next.mask);

        // apb answer: data sampled at setup, ready in first access cycle
        rdv = tcto_read(idx, state_reg);
        state_next.pready  = setup;
        state_next.pslverr = setup && !(aligned && rdv[32]);
        state_next.prdata  = (setup && !pwrite && aligned) ? rdv[31:0] : TCTO_RST_WORD;
    end

    // state register; everything clears to zero
    // zero after reset
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flip-flops; the oe_n pins through an inverter
    assign pready                      = state_reg.pready;
    assign prdata                      = state_reg.prdata;
    assign pslverr                     = state_reg.pslverr;
    assign counter_pin_0_out           = state_reg.toggle[0];
    assign counter_pin_1_out           = state_reg.toggle[1];
    assign counter_pin_0_oe_n          = ~state_reg.out_en[TCTO_TOG0_BIT];
    assign counter_pin_1_oe_n          = ~state_reg.out_en[TCTO_TOG1_BIT];
    assign baud_tick_timer_1           = state_reg.baud_tick;
    assign serial_sync_peripheral_mode = state_reg.out_en[TCTO_SERIAL_SYNC_PERIPHERAL_MODE_BIT];
    assign irq                         = state_reg.irq;

endmodule

`default_nettype wire

// File: testbench.sv
// self-checking bench for the timer control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import tcto_pkg::*;
    logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, irq, se;
    logic        ext0, ext1, ack_t0, ack_e0, pin0, pin1, out0, out1, oen0, oen1;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          e0, h0, e1, h1, n, err_count, cmp_count, cyc;
    tcto_timer_ctrl i_dut
    (
        .clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .pready,
        .prdata, .pslverr, .external_irq_pin_0(ext0), .external_irq_pin_1(ext1),
        .vector_ack_timer_0(ack_t0), .vector_ack_timer_1(1'b0), .vector_ack_ext_0(ack_e0),
        .vector_ack_ext_1(1'b0), .counter_pin_0_in(pin0), .counter_pin_1_in(pin1),
        .counter_pin_0_out(out0), .counter_pin_0_oe_n(oen0), .counter_pin_1_out(out1),
        .counter_pin_1_oe_n(oen1), .baud_tick_timer_1(), .serial_sync_peripheral_mode(),
        .irq
    );
    tcto_pin_load i_ld0 (.clock, .rst_b, .drv(out0), .oe_n(oen0), .level(pin0), .edges(e0), .half(h0));
    tcto_pin_load i_ld1 (.clock, .rst_b, .drv(out1), .oe_n(oen1), .level(pin1), .edges(e1), .half(h1));
    // ************************************************************
    // bus tasks and comparison
    // ************************************************************
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask
    // hold the request until pready is seen at an edge
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(logic [7:0] i, logic [31:0] d);
        apb(1'b1, {2'b00, i, 2'b00}, d);
    endtask
    task automatic rdc(logic [7:0] i, logic [31:0] exp, string name);
        apb(1'b0, {2'b00, i, 2'b00}, 32'h0000_0000);
        chk(name, rd, exp);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset;
        rdc(TCTO_IDX_RUN_FLAG, 32'h0000_0000, "run_flag");
        rdc(TCTO_IDX_MODE_SEL, 32'h0000_0000, "mode_sel");
        rdc(TCTO_IDX_OUT_EN, 32'h0000_0000, "out_en");
        chk("oe_n0", oen0, 1'b1);
        chk("out0", out0, 1'b0);
        apb(1'b0, 12'hC00, 32'h0000_0000);
        chk("slverr", se, 1'b1);
        chk("err_data", rd, 32'h0000_0000);
        $display("test reset done");
    endtask
    // reload FC, prescale 1: 4 ticks of 2 cycles per half period
    task automatic t_toggle;
        wr(TCTO_IDX_MODE_SEL, 32'h0000_0002);
        wr(TCTO_IDX_HIGH_0, 32'h0000_00FC);
        wr(TCTO_IDX_LOW_0, 32'h0000_00FC);
        wr(TCTO_IDX_PRESCALE, 32'h0000_0001);
        wr(TCTO_IDX_OUT_EN, 32'h0000_0040);
        wr(TCTO_IDX_RUN_FLAG, 32'h0000_0010);
        repeat (60) @(posedge clock);
        chk("half0", h0, 8);
        chk("pin1_edges", e1, 0);
        chk("oe_n1", oen1, 1'b1);
        rdc(TCTO_IDX_RUN_FLAG, 32'h0000_0030, "ovf0_set");
        wr(TCTO_IDX_MODE_SEL, 32'h0000_0003);
        // let a toggle launched at the write edge reach the load first
        repeat (2) @(posedge clock);
        n = e0;
        repeat (30) @(posedge clock);
        chk("mode3_stop", e0, n);
        wr(TCTO_IDX_MODE_SEL, 32'h0000_0002);
        wr(TCTO_IDX_RUN_FLAG, 32'h0000_0020);
        repeat (2) @(posedge clock);
        n = e0;
        repeat (40) @(posedge clock);
        chk("run_off", e0, n);
        @(posedge clock) ack_t0 <= 1'b1;
        @(posedge clock) ack_t0 <= 1'b0;
        rdc(TCTO_IDX_RUN_FLAG, 32'h0000_0000, "ovf0_ack");
        $display("test toggle done");
    endtask
    task automatic t_ext;
        wr(TCTO_IDX_IRQ_MASK, 32'h0000_0004);
        wr(TCTO_IDX_RUN_FLAG, 32'h0000_0001);
        rdc(TCTO_IDX_RUN_FLAG, 32'h0000_0001, "no_edge");
        @(posedge clock) ext0 <= 1'b0;
        repeat (3) @(posedge clock);
        chk("irq_up", irq, 1'b1);
        rdc(TCTO_IDX_RUN_FLAG, 32'h0000_0003, "ext0_set");
        @(posedge clock) ack_e0 <= 1'b1;
        @(posedge clock) ack_e0 <= 1'b0;
        rdc(TCTO_IDX_RUN_FLAG, 32'h0000_0001, "ext0_ack");
        // timer 0 overflows from the toggle test are still pending in bit 0
        rdc(TCTO_IDX_IRQ_STAT, 32'h0000_0005, "status");
        rdc(TCTO_IDX_IRQ_STAT, 32'h0000_0000, "status_clr");
        // irq falls at the clearing edge; look one edge later
        @(posedge clock);
        chk("irq_down", irq, 1'b0);
        wr(TCTO_IDX_IRQ_MASK, 32'h0000_0000);
        wr(TCTO_IDX_RUN_FLAG, 32'h0000_0000);
        rdc(TCTO_IDX_RUN_FLAG, 32'h0000_0002, "level_set");
        chk("irq_masked", irq, 1'b0);
        @(posedge clock) ext0 <= 1'b1;
        $display("test ext done");
    endtask
    task automatic t_gate;
        wr(TCTO_IDX_HIGH_1, 32'h0000_00FC);
        wr(TCTO_IDX_LOW_1, 32'h0000_00FC);
        wr(TCTO_IDX_MODE_SEL, 32'h0000_00A0);
        wr(TCTO_IDX_OUT_EN, 32'h0000_0080);
        ext1 <= 1'b0;
        wr(TCTO_IDX_RUN_FLAG, 32'h0000_0040);
        n = e1;
        repeat (40) @(posedge clock);
        chk("gated", e1, n);
        ext1 <= 1'b1;
        repeat (60) @(posedge clock);
        chk("ungated", e1 > n + 3, 1'b1);
        chk("half1", h1, 8);
        wr(TCTO_IDX_RUN_FLAG, 32'h0000_0000);
        $display("test gate done");
    endtask
    // ************************************************************
    // clock, reset, sequence and watchdog
    // ************************************************************
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            close_out();
        end
    end
    initial
    begin
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0000_0000; ext0 = 1'b1; ext1 = 1'b1; ack_t0 = 1'b0; ack_e0 = 1'b0;
        err_count = 0; cmp_count = 0; cyc = 0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        t_reset();
        t_toggle();
        t_ext();
        t_gate();
        close_out();
    end
endmodule
`default_nettype wire
